// ==== hdl/cftu_pkg.sv ====
/*
 * Constants, register map and instruction encodings of the compare and
 * trap unit. Assumes a 32-bit AXI4-Lite register bus on the core clock.
 */
package cftu_pkg;
    // Register byte offsets
    localparam logic [7:0] CFTU_OFF_INSTR  = 8'h00;
    localparam logic [7:0] CFTU_OFF_OPA    = 8'h04;
    localparam logic [7:0] CFTU_OFF_OPB    = 8'h08;
    localparam logic [7:0] CFTU_OFF_QREG   = 8'h0c;
    localparam logic [7:0] CFTU_OFF_SP     = 8'h10;
    localparam logic [7:0] CFTU_OFF_RESULT = 8'h14;
    localparam logic [7:0] CFTU_OFF_STATUS = 8'h18;
    localparam logic [7:0] CFTU_OFF_PTRA   = 8'h1c;
    localparam logic [7:0] CFTU_OFF_PTRB   = 8'h20;
    localparam logic [7:0] CFTU_OFF_PTRC   = 8'h24;
    localparam logic [7:0] CFTU_OFF_ROUND  = 8'h28;

    // Opcodes, register forms; bit 0 of a compare opcode is the M bit
    localparam logic [7:0] CFTU_OP_BYTECMP = 8'h2e;
    localparam logic [7:0] CFTU_OP_CMPEQ   = 8'h60;
    localparam logic [7:0] CFTU_OP_CMPGEU  = 8'h4e;
    localparam logic [7:0] CFTU_OP_CMPGTU  = 8'h4a;
    localparam logic [7:0] CFTU_OP_CMPLE   = 8'h44;
    localparam logic [7:0] CFTU_OP_CMPLTU  = 8'h42;
    localparam logic [7:0] CFTU_OP_CMPNE   = 8'h62;
    localparam logic [7:0] CFTU_OP_CONV    = 8'he4;
    localparam logic [7:0] CFTU_OP_DBLADD  = 8'hf4;
    localparam logic [7:0] CFTU_OP_DBLEQ   = 8'heb;
    localparam logic [7:0] CFTU_OP_DBLGE   = 8'hef;
    localparam logic [7:0] CFTU_OP_DIVU    = 8'h6a;

    // Trap vectors raised for unexecuted instructions (arbitrary values)
    localparam logic [7:0] CFTU_VEC_CONV   = 8'h28;
    localparam logic [7:0] CFTU_VEC_DBLADD = 8'h29;
    localparam logic [7:0] CFTU_VEC_DBLEQ  = 8'h2a;
    localparam logic [7:0] CFTU_VEC_DBLGE  = 8'h2b;
    localparam logic [7:0] CFTU_VEC_DIVU  = 8'h2c;
    localparam logic [7:0] CFTU_VEC_ILL   = 8'h2d;

    // Boolean words
    localparam logic [31:0] CFTU_TRUE  = 32'h8000_0000;
    localparam logic [31:0] CFTU_FALSE = 32'h0000_0000;

    // Conversion field layout inside the 8-bit operand field
    localparam int CFTU_USEL_BIT = 7;
    localparam int CFTU_ROUND_HI = 6;
    localparam int CFTU_ROUND_LO = 4;
    localparam int CFTU_DFMT_HI  = 3;
    localparam int CFTU_DFMT_LO  = 2;
    localparam int CFTU_SFMT_HI  = 1;
    localparam int CFTU_SFMT_LO  = 0;

    // Rounding and format codes
    localparam logic [2:0] CFTU_RMODE_NEAR = 3'h0;
    localparam logic [2:0] CFTU_RMODE_MINF = 3'h1;
    localparam logic [2:0] CFTU_RMODE_PINF = 3'h2;
    localparam logic [2:0] CFTU_RMODE_ZERO = 3'h3;
    localparam logic [2:0] CFTU_RMODE_ENV  = 3'h4;
    localparam logic [1:0] CFTU_FMT_INT  = 2'h0;
    localparam logic [1:0] CFTU_FMT_SGL  = 2'h1;
    localparam logic [1:0] CFTU_FMT_DBL  = 2'h2;
    localparam logic [1:0] CFTU_FMT_RSV  = 2'h3;

    // Status register bit positions
    localparam int CFTU_ST_DONE   = 0;
    localparam int CFTU_ST_TRAP   = 1;
    localparam int CFTU_ST_RNDRSV = 2;
    localparam int CFTU_ST_FMTRSV = 3;
    localparam int CFTU_ST_SAMEF  = 4;
    localparam int CFTU_ST_VEC_LO = 8;

    // AXI responses
    localparam logic [1:0] CFTU_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CFTU_RESP_DECERR = 2'h3;
endpackage : cftu_pkg

// ==== hdl/cftu_top.sv ====
/*
 * Compare and trap unit: integer compares execute, conversion, double
 * add/compare and unsigned divide raise traps that load the indirect
 * pointers. Assumes one clock, synchronous active-low reset and an
 * AXI4-Lite master that keeps to the usual valid/ready rules.
 */
// What this block does
// - Byte compare writes true if any of four byte lanes match.
// - Equal compare writes true when both 32-bit operands are identical.
// - Unsigned greater-or-equal compare writes true when first is not smaller.
// - Unsigned greater-than compare writes true only on strict excess.
// - Signed less-or-equal compare writes true when first is not greater.
// - Unsigned less-than compare writes true only when first is smaller.
// - Not-equal compare writes true when any bit differs.
// - M bit selects register operand or zero-extended 8-bit immediate.
// - Conversion traps; pointers get source, packed field, destination.
// - With unsigned select set, second pointer holds field plus stack pointer.
// - Conversion between like formats has no defined result.
// - Double add traps, pointers reference both sources and destination.
// - Double equal traps, pointers reference both sources and destination.
// - Double greater-or-equal traps, pointers reference sources and destination.
// - Double compares do not depend on environment rounding mode.
// - Unsigned divide of helper-register high half over first operand is left to the trap handler.
// - Unsigned divide traps, pointers reference sources and destination.
// - Rounding field codes 0-4 defined, 5-7 reserved.
// - Format codes integer, single, double; code 3 reserved.
module cftu_top
    import cftu_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        launch;
        logic [31:0] instr;
        logic [31:0] op_a;
        logic [31:0] op_b;
        logic [31:0] q_reg;
        logic [31:0] stack_ptr;
        logic [2:0]  env_round;
        logic [31:0] result;
        logic        done;
        logic        trap;
        logic [7:0]  vec;
        logic        rnd_rsv;
        logic        fmt_rsv;
        logic        same_fmt;
        logic [31:0] ptr_a;
        logic [31:0] ptr_b;
        logic [31:0] ptr_c;
    } cftu_state_t;

    cftu_state_t s_q;
    cftu_state_t s_d;

    // Instruction fields
    logic [7:0]  opcode;
    logic [7:0]  rc_num;
    logic [7:0]  ra_num;
    logic [7:0]  rb_field;
    logic [31:0] src_b;
    logic [3:0]  lane_eq;
    logic [31:0] status_word;
    logic [7:0]  conv_field;
    logic        do_write;
    logic [31:0] wmask;

    assign opcode   = s_q.instr[31:24];
    assign rc_num   = s_q.instr[23:16];
    assign ra_num   = s_q.instr[15:8];
    assign rb_field = s_q.instr[7:0];
    assign conv_field = rb_field;

    // operand select: register or zero-extended immediate
    assign src_b = opcode[0] ? {24'h00_0000, rb_field} : s_q.op_b;

    // Per-lane byte equality
    generate
        for (genvar i = 0; i < 4; i++) begin : g_lane
            assign lane_eq[i] = s_q.op_a[8*i +: 8] == src_b[8*i +: 8];
        end
    endgenerate

    assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    generate
        for (genvar j = 0; j < 4; j++) begin : g_strb
            assign wmask[8*j +: 8] = {8{s_q.w_strb[j]}};
        end
    endgenerate

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[CFTU_ST_DONE]   = s_q.done;
        status_word[CFTU_ST_TRAP]   = s_q.trap;
        status_word[CFTU_ST_RNDRSV] = s_q.rnd_rsv;
        status_word[CFTU_ST_FMTRSV] = s_q.fmt_rsv;
        status_word[CFTU_ST_SAMEF]  = s_q.same_fmt;
        status_word[CFTU_ST_VEC_LO +: 8] = s_q.vec;
    end

    // Next state: bus slave, register file and execution
    always_comb begin
        s_d = s_q;
        s_d.launch = 1'b0;
        // Address and data taken independently, in either order
        if (s_axi_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (do_write) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = CFTU_RESP_OKAY;
            unique case ({s_q.aw_addr[7:2], 2'b00})
                CFTU_OFF_INSTR: begin
                    s_d.instr  = (s_q.instr & ~wmask) | (s_q.w_data & wmask);
                    s_d.launch = 1'b1;
                    s_d.done   = 1'b0;
                end
                CFTU_OFF_OPA:
                    s_d.op_a = (s_q.op_a & ~wmask) | (s_q.w_data & wmask);
                CFTU_OFF_OPB:
                    s_d.op_b = (s_q.op_b & ~wmask) | (s_q.w_data & wmask);
                CFTU_OFF_QREG:
                    s_d.q_reg = (s_q.q_reg & ~wmask) | (s_q.w_data & wmask);
                CFTU_OFF_SP:
                    s_d.stack_ptr = (s_q.stack_ptr & ~wmask)
                                  | (s_q.w_data & wmask);
                CFTU_OFF_ROUND: begin
                    if (s_q.w_strb[0]) begin
                        s_d.env_round = s_q.w_data[2:0];
                    end
                end
                CFTU_OFF_RESULT, CFTU_OFF_STATUS, CFTU_OFF_PTRA,
                CFTU_OFF_PTRB, CFTU_OFF_PTRC: ;  // Read-only, write ignored
                default: s_d.bresp = CFTU_RESP_DECERR;
            endcase
        end
        // Read channel, one outstanding
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = CFTU_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                CFTU_OFF_INSTR:  s_d.rdata = s_q.instr;
                CFTU_OFF_OPA:    s_d.rdata = s_q.op_a;
                CFTU_OFF_OPB:    s_d.rdata = s_q.op_b;
                CFTU_OFF_QREG:   s_d.rdata = s_q.q_reg;
                CFTU_OFF_SP:     s_d.rdata = s_q.stack_ptr;
                CFTU_OFF_RESULT: s_d.rdata = s_q.result;
                CFTU_OFF_STATUS: s_d.rdata = status_word;
                CFTU_OFF_PTRA:   s_d.rdata = s_q.ptr_a;
                CFTU_OFF_PTRB:   s_d.rdata = s_q.ptr_b;
                CFTU_OFF_PTRC:   s_d.rdata = s_q.ptr_c;
                CFTU_OFF_ROUND:  s_d.rdata = {29'h0, s_q.env_round};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = CFTU_RESP_DECERR;
                end
            endcase
        end
        // Execute the instruction written one cycle earlier
        if (s_q.launch) begin
            s_d.done     = 1'b1;
            s_d.trap     = 1'b0;
            s_d.vec      = 8'h00;
            s_d.rnd_rsv  = 1'b0;
            s_d.fmt_rsv  = 1'b0;
            s_d.same_fmt = 1'b0;
            unique case ({opcode[7:1], 1'b0})
                CFTU_OP_BYTECMP:
                    s_d.result = |lane_eq ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPEQ:
                    s_d.result = s_q.op_a == src_b ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPNE:
                    s_d.result = s_q.op_a != src_b ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPGEU:
                    s_d.result = s_q.op_a >= src_b ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPGTU:
                    s_d.result = s_q.op_a > src_b ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPLE:
                    s_d.result = $signed(s_q.op_a) <= $signed(src_b)
                               ? CFTU_TRUE : CFTU_FALSE;
                CFTU_OP_CMPLTU:
                    s_d.result = s_q.op_a < src_b ? CFTU_TRUE : CFTU_FALSE;
                default: begin
                    s_d.trap  = 1'b1;
                    s_d.ptr_a = {24'h00_0000, ra_num};
                    s_d.ptr_b = {24'h00_0000, rb_field};
                    s_d.ptr_c = {24'h00_0000, rc_num};
                    unique case (opcode)
                        CFTU_OP_CONV: begin
                            s_d.vec = CFTU_VEC_CONV;
                            s_d.ptr_b = conv_field[CFTU_USEL_BIT]
                                ? {24'h00_0000, conv_field} + s_q.stack_ptr
                                : {24'h00_0000, conv_field};
                            s_d.rnd_rsv =
                                conv_field[CFTU_ROUND_HI:CFTU_ROUND_LO]
                                > CFTU_RMODE_ENV;
                            s_d.fmt_rsv =
                                conv_field[CFTU_DFMT_HI:CFTU_DFMT_LO]
                                == CFTU_FMT_RSV
                                || conv_field[CFTU_SFMT_HI:CFTU_SFMT_LO]
                                == CFTU_FMT_RSV;
                            s_d.same_fmt =
                                conv_field[CFTU_DFMT_HI:CFTU_DFMT_LO]
                                == conv_field[CFTU_SFMT_HI:CFTU_SFMT_LO];
                        end
                        CFTU_OP_DBLADD: s_d.vec = CFTU_VEC_DBLADD;
                        // double equal trap, no rounding use
                        CFTU_OP_DBLEQ:  s_d.vec = CFTU_VEC_DBLEQ;
                        // double ge trap, no rounding use
                        CFTU_OP_DBLGE:  s_d.vec = CFTU_VEC_DBLGE;
                        // divide of helper:first left to handler
                        CFTU_OP_DIVU: s_d.vec = CFTU_VEC_DIVU;
                        default:      s_d.vec = CFTU_VEC_ILL;
                    endcase
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready  = !s_q.w_have;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence seq_launch(logic [7:0] op);
        s_q.launch && ({opcode[7:1], 1'b0} == op);
    endsequence

    a_byte_compare: assert property (
        seq_launch(CFTU_OP_BYTECMP) |=> s_q.result ==
            ($past(|lane_eq) ? CFTU_TRUE : CFTU_FALSE))
        else $error("byte compare result wrong");
    a_equal_result: assert property (
        seq_launch(CFTU_OP_CMPEQ) |=> s_q.result ==
            ($past(s_q.op_a == src_b) ? CFTU_TRUE : CFTU_FALSE))
        else $error("equal compare result wrong");
    a_ge_unsigned: assert property (
        seq_launch(CFTU_OP_CMPGEU) |=> s_q.result[31] ==
            $past(s_q.op_a >= src_b))
        else $error("unsigned ge result wrong");
    a_gt_unsigned: assert property (
        seq_launch(CFTU_OP_CMPGTU) |=> s_q.result[31] ==
            $past(s_q.op_a > src_b))
        else $error("unsigned gt result wrong");
    a_le_signed: assert property (
        seq_launch(CFTU_OP_CMPLE) |=> s_q.result[31] ==
            $past($signed(s_q.op_a) <= $signed(src_b)))
        else $error("signed le result wrong");
    a_lt_unsigned: assert property (
        seq_launch(CFTU_OP_CMPLTU) |=> s_q.result[31] ==
            $past(s_q.op_a < src_b))
        else $error("unsigned lt result wrong");
    a_not_equal: assert property (
        seq_launch(CFTU_OP_CMPNE) |=> s_q.result[31] ==
            $past(s_q.op_a != src_b))
        else $error("not-equal result wrong");
    a_imm_zero_ext: assert property (
        opcode[0] |-> src_b[31:8] == 24'h00_0000)
        else $error("immediate not zero-extended");
    a_conv_trap_ptr: assert property (
        s_q.launch && opcode == CFTU_OP_CONV |=> s_q.trap && s_q.done
            && s_q.vec == CFTU_VEC_CONV && s_q.ptr_a[7:0] == $past(ra_num))
        else $error("conversion trap pointers wrong");
    a_conv_sp_bias: assert property (
        s_q.launch && opcode == CFTU_OP_CONV && conv_field[CFTU_USEL_BIT]
            |=> s_q.ptr_b == 32'($past(conv_field)) + $past(s_q.stack_ptr))
        else $error("stack pointer bias missing");
    a_dbl_add_trap: assert property (
        s_q.launch && opcode == CFTU_OP_DBLADD |=> s_q.trap
            && s_q.vec == CFTU_VEC_DBLADD && s_q.ptr_c[7:0] == $past(rc_num))
        else $error("double add did not trap");
    a_divide_trap: assert property (
        s_q.launch && opcode == CFTU_OP_DIVU |=> s_q.trap
            && s_q.vec == CFTU_VEC_DIVU && s_q.ptr_b[7:0] == $past(rb_field))
        else $error("divide did not trap");
    a_bool_word: assert property (
        s_q.done && !s_q.trap |-> s_q.result == CFTU_TRUE
            || s_q.result == CFTU_FALSE)
        else $error("result not a boolean word");
endmodule : cftu_top

// ==== test/cftu_top_tb.sv ====
/*
 * Self-checking bench for the compare and trap unit: compares, traps,
 * register access and bus errors, all through the AXI4-Lite port.
 * Assumes every register resets to zero and every request is answered.
 */
module cftu_top_tb
    import cftu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock         = 1'b0;
    logic        reset_n       = 1'b0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hf;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b1;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b1;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    int          n_errors      = 0;
    int          cmp_count     = 0;

    cftu_top i_cftu_top (
        .clock         (clock),
        .reset_n       (reset_n),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp)
    );

    // 200 MHz core clock
    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic chk32(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk32

    task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_resp

    // Write: offer address and data, drop each when taken, wait response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        r = s_axi_bresp;
        if (n >= 100) n_errors++;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 100) n_errors++;
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk32(e, d);
    endtask : rd_chk

    // Load operands, launch, poll done
    task automatic run_instr(input logic [31:0] ins, input logic [31:0] a,
                             input logic [31:0] b, output logic [31:0] st);
        logic [1:0] r;
        int         n;
        axi_wr(CFTU_OFF_OPA, a, r);
        axi_wr(CFTU_OFF_OPB, b, r);
        axi_wr(CFTU_OFF_INSTR, ins, r);
        n = 0;
        do begin
            axi_rd(CFTU_OFF_STATUS, st, r);
            n++;
        end while (st[CFTU_ST_DONE] !== 1'b1 && n < 20);
        if (st[CFTU_ST_DONE] !== 1'b1) n_errors++;
    endtask : run_instr

    function automatic logic [31:0] cmp_ref(input logic [7:0] op,
                                            input logic [31:0] a,
                                            input logic [31:0] b);
        logic t;
        case ({op[7:1], 1'b0})
            CFTU_OP_BYTECMP: t = (a[7:0] == b[7:0]) || (a[15:8] == b[15:8])
                              || (a[23:16] == b[23:16])
                              || (a[31:24] == b[31:24]);
            CFTU_OP_CMPEQ:   t = (a == b);
            CFTU_OP_CMPGEU:  t = (a >= b);
            CFTU_OP_CMPGTU:  t = (a > b);
            CFTU_OP_CMPLE:   t = ($signed(a) <= $signed(b));
            CFTU_OP_CMPLTU:  t = (a < b);
            default:        t = (a != b);
        endcase
        return t ? 32'h8000_0000 : 32'h0000_0000;
    endfunction : cmp_ref

    // Reset values, read-write and read-only places, unmapped offsets
    task automatic t_regs();
        logic [7:0]  ro[5] = '{CFTU_OFF_STATUS, CFTU_OFF_RESULT,
                               CFTU_OFF_PTRA, CFTU_OFF_PTRB, CFTU_OFF_PTRC};
        logic [31:0] d;
        logic [1:0]  r;
        foreach (ro[i]) rd_chk(ro[i], 32'h0);
        axi_wr(CFTU_OFF_RESULT, 32'hdead_beef, r);
        chk_resp(CFTU_RESP_OKAY, r);
        rd_chk(CFTU_OFF_RESULT, 32'h0);
        axi_wr(CFTU_OFF_QREG, 32'hcafe_0001, r);
        rd_chk(CFTU_OFF_QREG, 32'hcafe_0001);
        axi_wr(CFTU_OFF_ROUND, {29'h0, CFTU_RMODE_ENV}, r);
        rd_chk(CFTU_OFF_ROUND, {29'h0, CFTU_RMODE_ENV});
        axi_rd(8'h2c, d, r);
        chk_resp(CFTU_RESP_DECERR, r);
        chk32(32'h0, d);
        axi_wr(8'h40, 32'h1234_5678, r);
        chk_resp(CFTU_RESP_DECERR, r);
    endtask : t_regs

    // Every named trapping opcode, no illegal opcode: vector, pointers, status flags, result kept
    task automatic t_traps();
        logic [7:0]  ops[6] = '{CFTU_OP_CONV, CFTU_OP_CONV, CFTU_OP_DBLADD,
                                CFTU_OP_DBLEQ, CFTU_OP_DBLGE, CFTU_OP_DIVU};
        logic [7:0]  vec[6] = '{CFTU_VEC_CONV, CFTU_VEC_CONV, CFTU_VEC_DBLADD,
                                CFTU_VEC_DBLEQ, CFTU_VEC_DBLGE, CFTU_VEC_DIVU};
        logic [7:0]  fld[6] = '{8'h9d, 8'h75, 8'h12, 8'h34, 8'h56, 8'h78};
        // Expected like-format, reserved-format, reserved-rounding bits
        logic [2:0]  flg[6] = '{3'h2, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0};
        logic [31:0] st, res, exp_b;
        logic [7:0]  ra, rc;
        logic [1:0]  r;
        axi_wr(CFTU_OFF_SP, 32'h0000_0400, r);
        axi_rd(CFTU_OFF_RESULT, res, r);
        foreach (ops[i]) begin
            ra = 8'h20 + 8'(i);
            rc = 8'h40 + 8'(i);
            exp_b = {24'h0, fld[i]};
            if (i == 0) exp_b = exp_b + 32'h0000_0400;
            run_instr({ops[i], rc, ra, fld[i]}, 32'h1, 32'h2, st);
            chk32(32'h1, {31'h0, st[CFTU_ST_TRAP]});
            chk32({24'h0, vec[i]}, {24'h0, st[15:8]});
            chk32({29'h0, flg[i]}, {29'h0, st[4:2]});
            rd_chk(CFTU_OFF_PTRA, {24'h0, ra});
            rd_chk(CFTU_OFF_PTRB, exp_b);
            rd_chk(CFTU_OFF_PTRC, {24'h0, rc});
            rd_chk(CFTU_OFF_RESULT, res);
        end
    endtask : t_traps

    // All compares, both operand forms, boundary operand pairs
    task automatic t_compares();
        logic [7:0]  ops[7] = '{CFTU_OP_BYTECMP, CFTU_OP_CMPEQ,
                                CFTU_OP_CMPGEU, CFTU_OP_CMPGTU, CFTU_OP_CMPLE,
                                CFTU_OP_CMPLTU, CFTU_OP_CMPNE};
        logic [31:0] va[6] = '{32'h5, 32'h8000_0000, 32'h1, 32'hffff_ffff,
                               32'h1234_5678, 32'h1122_3344};
        logic [31:0] vb[6] = '{32'h5, 32'h1, 32'h8000_0000, 32'hffff_fffe,
                               32'h9a34_bcde, 32'h4433_2211};
        logic [31:0] st, sb;
        logic [7:0]  op;
        foreach (ops[i]) for (int j = 0; j < 6; j++) begin
            for (int m = 0; m < 2; m++) begin
                op = ops[i] | 8'(m);
                sb = (m == 1) ? {24'h0, vb[j][7:0]} : vb[j];
                run_instr({op, 8'h07, 8'h03, vb[j][7:0]}, va[j],
                          (m == 1) ? ~vb[j] : vb[j], st);
                chk32(32'h0, {31'h0, st[CFTU_ST_TRAP]});
                rd_chk(CFTU_OFF_RESULT, cmp_ref(op, va[j], sb));
            end
        end
        rd_chk(CFTU_OFF_PTRA, 32'h25);
    endtask : t_compares

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_traps();
        t_compares();
        end_sim();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        end_sim();
    end
endmodule : cftu_top_tb
